// *** src/fdoc_pkg.sv ***
package fdoc_pkg;
    localparam int ADDR_W = 48;
    localparam int BLOCK_BYTES = 32;
    localparam int ENTRY_BYTES = 16;
    localparam int Q_ENTRIES = 20;
    localparam int DEC_SLOTS = 4;
    localparam int OC_SLOTS = 8;
    localparam int OC_SETS = 64;
    localparam int OC_WAYS = 8;
    localparam int OC_LINES = OC_SETS * OC_WAYS;
    localparam int OP_W = 16;
    localparam int BUF_W = OP_W * OC_SLOTS + OC_SLOTS + 2;

    localparam logic [4:0] Q_LAST_ALL = 5'h13;
    localparam logic [4:0] Q_LAST_T0 = 5'h09;
    localparam logic [4:0] Q_BASE_T0 = 5'h00;
    localparam logic [4:0] Q_BASE_T1 = 5'h0A;
    localparam logic [5:0] Q_SIZE_ALL = 6'h14;
    localparam logic [5:0] Q_SIZE_THR = 6'h0A;
    localparam logic [5:0] FETCH_ENTRIES = 6'h02;
    localparam logic [5:0] WIN_ONE = 6'h10;
    localparam logic [5:0] WIN_TWO = 6'h20;
    localparam logic [4:0] LEN_LONG_MAX = 5'h08;
    localparam logic [4:0] LEN_MAX = 5'h0F;
    localparam logic [3:0] OC_MAX_OPS = 4'h8;
    localparam logic [3:0] OC_MAX_IMM = 4'h8;
    localparam logic [2:0] OC_MAX_UCODE = 3'h4;
    localparam logic [7:0] SP_STEP = 8'h08;
    localparam logic [ADDR_W-1:0] BLOCK_STEP = 48'h20;

    localparam logic [1:0] KIND_PUSH = 2'h1;
    localparam logic [1:0] KIND_POP = 2'h2;
    localparam logic [1:0] KIND_UCODE = 2'h3;

    localparam logic [ADDR_W-1:0] ADDR_RST = 48'h0;
    localparam logic [4:0] PTR_RST = 5'h00;
    localparam logic [7:0] SP_RST = 8'h00;

    typedef enum logic {
        MODE_ICACHE_SUPPLY = 1'b0,
        MODE_DECODED_SUPPLY = 1'b1
    } fdoc_mode_e;
endpackage

// *** src/fdoc_skid_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdoc_skid_buf #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic spare_valid_reg;
    logic [W-1:0] spare_data_reg;

    // two entries: the output stage and one spare taken while stalled
    assign in_ready = !spare_valid_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            spare_valid_reg <= 1'b0;
        end else if (!out_valid || out_ready) begin
            if (spare_valid_reg) begin
                out_valid <= 1'b1;
                spare_valid_reg <= 1'b0;
            end else begin
                out_valid <= in_valid;
            end
        end else if (in_valid && !spare_valid_reg) begin
            spare_valid_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!out_valid || out_ready) begin
            out_data <= spare_valid_reg ? spare_data_reg : in_data;
        end
        if (in_valid && !spare_valid_reg && out_valid && !out_ready) begin
            spare_data_reg <= in_data;
        end
    end
endmodule // fdoc_skid_buf
`default_nettype wire

// *** src/fdoc_front_end.sv ***
// Operation
// - fetch aligned 32-byte blocks, one per cycle
// - byte queue: 20 entries of 16 bytes
// - two threads: 10 dedicated entries each
// - queue decouples fetch side from decoder
// - scan two entries, decode at most four
// - sideband stack-pointer tracker removes push/pop dependencies
// - pick window 32 bytes, 16-byte aligned
// - only slot zero takes instructions over eight bytes
// - op-store supply bypasses fetch and decode
// - op-store eight per cycle, decoder four
// - op store: 64 sets, 8 ways, 8 ops
// - decoded instructions build entries within 64-byte region
// - close entry at 8 ops, 8 immediates, 4 microcoded
// - entry ends at its 64-byte region end
// - enter decoded supply only at branch target
// - leave decoded supply on op-store miss
// - op store only under flat memory model
`timescale 1ns/1ps
`default_nettype none
module fdoc_front_end
    import fdoc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic dual_thread_mode,
    input wire logic long_mode,
    input wire logic cs_base_zero,
    input wire logic cs_limit_max,
    input wire logic redirect_valid,
    input wire logic redirect_thread,
    input wire logic [ADDR_W-1:0] redirect_addr,
    output logic ic_req_valid,
    output logic ic_req_thread,
    output logic [ADDR_W-1:0] ic_req_addr,
    input wire logic [BLOCK_BYTES*8-1:0] ic_rsp_data,
    input wire logic sp_sync,
    output logic decoded_supply_mode,
    output logic op_valid,
    input wire logic op_ready,
    output logic [OC_SLOTS-1:0] op_mask,
    output logic [OP_W*OC_SLOTS-1:0] op_data,
    output logic op_thread,
    output logic op_from_cache
);
    ////////////////////////////////////////////////////////////////////////////
    logic [ENTRY_BYTES*8-1:0] q_reg [Q_ENTRIES];
    logic [4:0] q_head_reg [2];
    logic [4:0] q_tail_reg [2];
    logic [5:0] q_cnt_reg [2];
    logic [4:0] pick_off_reg [2];
    logic [ADDR_W-1:0] pick_pc_reg [2];
    logic [ADDR_W-1:0] fetch_pc_reg [2];
    logic [7:0] sp_delta_reg [2];
    logic req_pend_reg;
    logic req_thr_reg;
    logic req_drop_reg;
    logic fetch_turn_reg;
    logic dec_turn_reg;
    fdoc_mode_e mode_reg;
    fdoc_mode_e mode_next;
    logic [ADDR_W-1:0] oc_pc_reg;
    logic [3:0] bld_cnt_reg;
    logic [3:0] bld_imm_reg;
    logic [2:0] bld_uc_reg;
    logic [ADDR_W-1:0] bld_start_reg;
    logic [ADDR_W-7:0] bld_region_reg;
    logic [ADDR_W-1:0] bld_next_reg;
    logic [63:0] bld_ops_reg;
    logic oc_valid_reg [OC_LINES];
    logic [ADDR_W-13:0] oc_tag_reg [OC_LINES];
    logic [5:0] oc_start_reg [OC_LINES];
    logic [3:0] oc_cnt_reg [OC_LINES];
    logic [ADDR_W-1:0] oc_next_reg [OC_LINES];
    logic [63:0] oc_ops_reg [OC_LINES];
    logic [2:0] oc_repl_reg [OC_SETS];

    logic dual;
    logic oc_en;
    logic [4:0] q_base [2];
    logic [4:0] q_last [2];
    logic [5:0] q_size [2];
    logic thr_on [2];
    logic restart [2];
    logic [ADDR_W-1:0] rs_addr [2];
    logic redir0;
    logic lk_hit;
    logic [8:0] lk_idx;
    logic [8:0] way_idx;
    logic [ADDR_W-1:0] lk_addr;
    logic oc_exit;
    logic oc_deliver;
    logic buf_in_ready;
    logic want [2];
    logic [5:0] inflight;
    logic f_go;
    logic f_thr;
    logic rsp_ok;

    function automatic logic [4:0] q_step(input logic [4:0] p, input logic [4:0] last,
                                          input logic [4:0] base);
        return (p == last) ? base : p + 5'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // queue partition, flat-model gate and op-store lookup
    always_comb begin
        dual = dual_thread_mode;
        oc_en = !dual && (long_mode || (cs_base_zero && cs_limit_max));
        q_base[0] = Q_BASE_T0;
        q_base[1] = Q_BASE_T1;
        q_last[0] = dual ? Q_LAST_T0 : Q_LAST_ALL;
        q_last[1] = Q_LAST_ALL;
        q_size[0] = dual ? Q_SIZE_THR : Q_SIZE_ALL;
        q_size[1] = Q_SIZE_THR;
        thr_on[0] = 1'b1;
        thr_on[1] = dual;
        redir0 = redirect_valid && !redirect_thread;
        lk_addr = redir0 ? redirect_addr : oc_pc_reg;
        lk_hit = 1'b0;
        lk_idx = 9'h000;
        way_idx = 9'h000;
        for (int w = 0; w < OC_WAYS; w++) begin
            way_idx = {lk_addr[11:6], 3'(w)};
            if (oc_valid_reg[way_idx] && oc_tag_reg[way_idx] == lk_addr[ADDR_W-1:12]
                && oc_start_reg[way_idx] == lk_addr[5:0]) begin
                lk_hit = 1'b1;
                lk_idx = way_idx;
            end
        end
        lk_hit = lk_hit && oc_en;
        oc_exit = !redir0 && mode_reg == MODE_DECODED_SUPPLY && !lk_hit;
        oc_deliver = !redir0 && mode_reg == MODE_DECODED_SUPPLY && lk_hit && buf_in_ready;
        if (redir0) begin
            mode_next = lk_hit ? MODE_DECODED_SUPPLY : MODE_ICACHE_SUPPLY;
        end else if (oc_exit) begin
            mode_next = MODE_ICACHE_SUPPLY;
        end else begin
            mode_next = mode_reg;
        end
        restart[0] = redir0 || oc_exit;
        restart[1] = redirect_valid && redirect_thread && dual;
        rs_addr[0] = redir0 ? redirect_addr : oc_pc_reg;
        rs_addr[1] = redirect_addr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch choice: space counted with blocks still in flight
    always_comb begin
        inflight = 6'h00;
        for (int t = 0; t < 2; t++) begin
            inflight = 6'h00;
            if (ic_req_valid && ic_req_thread == 1'(t)) begin
                inflight = inflight + FETCH_ENTRIES;
            end
            if (req_pend_reg && req_thr_reg == 1'(t)) begin
                inflight = inflight + FETCH_ENTRIES;
            end
            want[t] = thr_on[t] && !restart[t]
                && (q_cnt_reg[t] + inflight + FETCH_ENTRIES <= q_size[t]);
        end
        want[0] = want[0] && mode_next == MODE_ICACHE_SUPPLY;
        f_thr = want[1] && (!want[0] || fetch_turn_reg);
        f_go = want[0] || want[1];
        rsp_ok = req_pend_reg && !req_drop_reg && !restart[req_thr_reg];
    end

    ////////////////////////////////////////////////////////////////////////////
    // picker and decoder over the two-entry window
    logic dt;
    logic dec_act;
    logic bld_en;
    logic [4:0] hd;
    logic [2*ENTRY_BYTES*8-1:0] window;
    logic [5:0] wlim;
    logic [5:0] pos;
    logic [5:0] pos_m;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] ins_end;
    logic go;
    logic close;
    logic pop;
    logic [4:0] new_off;
    logic [7:0] b;
    logic [4:0] len;
    logic [3:0] imm;
    logic uc;
    logic fit_w;
    logic fit_s;
    logic fit_b;
    logic [3:0] c_cnt;
    logic [3:0] c_imm;
    logic [2:0] c_uc;
    logic [ADDR_W-1:0] c_start;
    logic [ADDR_W-7:0] c_region;
    logic [ADDR_W-1:0] c_next;
    logic [63:0] c_ops;
    logic [DEC_SLOTS-1:0] d_mask;
    logic [DEC_SLOTS*8-1:0] d_bytes;

    always_comb begin
        dt = dual && q_cnt_reg[1] != 6'h00 && (q_cnt_reg[0] == 6'h00 || dec_turn_reg);
        dec_act = q_cnt_reg[dt] != 6'h00 && !restart[dt] && buf_in_ready
            && (dt || mode_reg == MODE_ICACHE_SUPPLY);
        bld_en = oc_en && !dt;
        hd = q_head_reg[dt];
        window = {(q_cnt_reg[dt] >= 6'h02) ? q_reg[q_step(hd, q_last[dt], q_base[dt])]
                                           : {ENTRY_BYTES*8{1'b0}}, q_reg[hd]};
        wlim = (q_cnt_reg[dt] >= 6'h02) ? WIN_TWO : WIN_ONE;
        pos = {1'b0, pick_off_reg[dt]};
        pc = pick_pc_reg[dt];
        go = dec_act;
        close = 1'b0;
        c_cnt = bld_cnt_reg;
        c_imm = bld_imm_reg;
        c_uc = bld_uc_reg;
        c_start = bld_start_reg;
        c_region = bld_region_reg;
        c_next = bld_next_reg;
        c_ops = bld_ops_reg;
        d_mask = 4'h0;
        d_bytes = 32'h0000_0000;
        b = 8'h00;
        len = 5'h00;
        imm = 4'h0;
        uc = 1'b0;
        ins_end = ADDR_RST;
        fit_w = 1'b0;
        fit_s = 1'b0;
        fit_b = 1'b0;
        for (int s = 0; s < DEC_SLOTS; s++) begin
            b = window[{pos[4:0], 3'b000} +: 8];
            len = (b[3:0] == 4'hF) ? LEN_MAX : {1'b0, b[3:0]} + 5'h01;
            imm = {2'b00, b[5:4]};
            uc = b[7:6] == KIND_UCODE;
            ins_end = pc + ADDR_W'(len) - 48'h1;
            fit_w = pos + {1'b0, len} <= wlim;
            fit_s = s == 0 || len <= LEN_LONG_MAX;
            fit_b = !bld_en || c_cnt == 4'h0
                || (c_cnt < OC_MAX_OPS && c_imm + imm <= OC_MAX_IMM
                    && c_uc + 3'(uc) <= OC_MAX_UCODE
                    && ins_end[ADDR_W-1:6] == c_region);
            if (go && fit_w && fit_s && fit_b) begin
                d_bytes[s*8 +: 8] = b;
                d_mask[s] = 1'b1;
                if (bld_en) begin
                    if (c_cnt == 4'h0) begin
                        c_start = pc;
                        c_region = ins_end[ADDR_W-1:6];
                    end
                    c_ops[{c_cnt[2:0], 3'b000} +: 8] = b;
                    c_cnt = c_cnt + 4'h1;
                    c_imm = c_imm + imm;
                    c_uc = c_uc + 3'(uc);
                    c_next = pc + ADDR_W'(len);
                end
                pos = pos + {1'b0, len};
                pc = pc + ADDR_W'(len);
            end else begin
                close = close || (go && fit_w && fit_s && !fit_b);
                go = 1'b0;
            end
        end
        pop = dec_act && pos >= WIN_ONE;
        pos_m = pos - WIN_ONE;
        new_off = pop ? pos_m[4:0] : pos[4:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // output group and stack-pointer tracker
    logic g_valid;
    logic g_thr;
    logic [63:0] g_bytes;
    logic [OC_SLOTS-1:0] g_mask;
    logic [OP_W*OC_SLOTS-1:0] g_ops;
    logic [7:0] d_sp;

    always_comb begin
        g_valid = oc_deliver || d_mask != 4'h0;
        g_thr = oc_deliver ? 1'b0 : dt;
        g_bytes = oc_deliver ? oc_ops_reg[lk_idx] : {32'h0000_0000, d_bytes};
        g_mask = {4'h0, d_mask};
        if (oc_deliver) begin
            for (int i = 0; i < OC_SLOTS; i++) begin
                g_mask[i] = 4'(i) < oc_cnt_reg[lk_idx];
            end
        end
        d_sp = sp_sync ? SP_RST : sp_delta_reg[g_thr];
        g_ops = {OP_W*OC_SLOTS{1'b0}};
        for (int i = 0; i < OC_SLOTS; i++) begin
            if (g_mask[i] && g_bytes[i*8+6 +: 2] == KIND_PUSH) begin
                d_sp = d_sp - SP_STEP;
            end else if (g_mask[i] && g_bytes[i*8+6 +: 2] == KIND_POP) begin
                d_sp = d_sp + SP_STEP;
            end
            g_ops[i*OP_W +: OP_W] = g_mask[i] ? {g_bytes[i*8 +: 8], d_sp} : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch requests, one aligned block per cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ic_req_valid <= 1'b0;
            ic_req_thread <= 1'b0;
            ic_req_addr <= ADDR_RST;
            fetch_turn_reg <= 1'b0;
            req_pend_reg <= 1'b0;
            req_thr_reg <= 1'b0;
            req_drop_reg <= 1'b0;
            for (int t = 0; t < 2; t++) begin
                fetch_pc_reg[t] <= ADDR_RST;
            end
        end else begin
            ic_req_valid <= f_go;
            if (f_go) begin
                ic_req_thread <= f_thr;
                ic_req_addr <= fetch_pc_reg[f_thr];
                fetch_turn_reg <= !f_thr;
            end
            req_pend_reg <= ic_req_valid;
            req_thr_reg <= ic_req_thread;
            req_drop_reg <= restart[ic_req_thread];
            for (int t = 0; t < 2; t++) begin
                if (restart[t]) begin
                    fetch_pc_reg[t] <= {rs_addr[t][ADDR_W-1:5], 5'h00};
                end else if (f_go && f_thr == 1'(t)) begin
                    fetch_pc_reg[t] <= fetch_pc_reg[t] + BLOCK_STEP;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte queue storage and per-thread pointers
    always_ff @(posedge sys_clk) begin
        if (rsp_ok) begin
            q_reg[q_tail_reg[req_thr_reg]] <= ic_rsp_data[ENTRY_BYTES*8-1:0];
            q_reg[q_step(q_tail_reg[req_thr_reg], q_last[req_thr_reg], q_base[req_thr_reg])]
                <= ic_rsp_data[BLOCK_BYTES*8-1:ENTRY_BYTES*8];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dec_turn_reg <= 1'b0;
            for (int t = 0; t < 2; t++) begin
                q_head_reg[t] <= PTR_RST;
                q_tail_reg[t] <= PTR_RST;
                q_cnt_reg[t] <= 6'h00;
                pick_off_reg[t] <= PTR_RST;
                pick_pc_reg[t] <= ADDR_RST;
            end
        end else begin
            if (dec_act) begin
                dec_turn_reg <= !dt;
            end
            for (int t = 0; t < 2; t++) begin
                if (restart[t]) begin
                    q_head_reg[t] <= q_base[t];
                    q_tail_reg[t] <= q_base[t];
                    q_cnt_reg[t] <= 6'h00;
                    pick_off_reg[t] <= rs_addr[t][4:0];
                    pick_pc_reg[t] <= rs_addr[t];
                end else begin
                    if (rsp_ok && req_thr_reg == 1'(t)) begin
                        q_tail_reg[t] <= q_step(q_step(q_tail_reg[t], q_last[t], q_base[t]),
                                                q_last[t], q_base[t]);
                    end
                    if (pop && dt == 1'(t)) begin
                        q_head_reg[t] <= q_step(q_head_reg[t], q_last[t], q_base[t]);
                    end
                    q_cnt_reg[t] <= q_cnt_reg[t]
                        + ((rsp_ok && req_thr_reg == 1'(t)) ? FETCH_ENTRIES : 6'h00)
                        - ((pop && dt == 1'(t)) ? 6'h01 : 6'h00);
                    if (dec_act && dt == 1'(t)) begin
                        pick_off_reg[t] <= new_off;
                        pick_pc_reg[t] <= pc;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supply mode and decoded-supply address
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= MODE_ICACHE_SUPPLY;
            decoded_supply_mode <= 1'b0;
            oc_pc_reg <= ADDR_RST;
        end else begin
            mode_reg <= mode_next;
            decoded_supply_mode <= mode_next == MODE_DECODED_SUPPLY;
            if (redir0) begin
                oc_pc_reg <= redirect_addr;
            end else if (oc_deliver) begin
                oc_pc_reg <= oc_next_reg[lk_idx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // entry under construction and op-store fill
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bld_cnt_reg <= 4'h0;
            bld_imm_reg <= 4'h0;
            bld_uc_reg <= 3'h0;
            bld_start_reg <= ADDR_RST;
            bld_region_reg <= 42'h000_0000_0000;
            bld_next_reg <= ADDR_RST;
            bld_ops_reg <= 64'h0;
        end else if (restart[0] || !oc_en || close) begin
            bld_cnt_reg <= 4'h0;
            bld_imm_reg <= 4'h0;
            bld_uc_reg <= 3'h0;
        end else if (dec_act && bld_en) begin
            bld_cnt_reg <= c_cnt;
            bld_imm_reg <= c_imm;
            bld_uc_reg <= c_uc;
            bld_start_reg <= c_start;
            bld_region_reg <= c_region;
            bld_next_reg <= c_next;
            bld_ops_reg <= c_ops;
        end
    end

    logic [8:0] wr_idx;
    assign wr_idx = {c_start[11:6], oc_repl_reg[c_start[11:6]]};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < OC_LINES; i++) begin
                oc_valid_reg[i] <= 1'b0;
            end
            for (int s = 0; s < OC_SETS; s++) begin
                oc_repl_reg[s] <= 3'h0;
            end
        end else if (close) begin
            oc_valid_reg[wr_idx] <= 1'b1;
            oc_repl_reg[c_start[11:6]] <= oc_repl_reg[c_start[11:6]] + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (close) begin
            oc_tag_reg[wr_idx] <= c_start[ADDR_W-1:12];
            oc_start_reg[wr_idx] <= c_start[5:0];
            oc_cnt_reg[wr_idx] <= c_cnt;
            oc_next_reg[wr_idx] <= c_next;
            oc_ops_reg[wr_idx] <= c_ops;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tracker state and output buffer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int t = 0; t < 2; t++) begin
                sp_delta_reg[t] <= SP_RST;
            end
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (g_valid && g_thr == 1'(t)) begin
                    sp_delta_reg[t] <= d_sp;
                end else if (sp_sync) begin
                    sp_delta_reg[t] <= SP_RST;
                end
            end
        end
    end

    logic [BUF_W-1:0] buf_out;

    fdoc_skid_buf #(
        .W(BUF_W)
    ) u_out_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(g_valid),
        .in_ready(buf_in_ready),
        .in_data({oc_deliver, g_thr, g_mask, g_ops}),
        .out_valid(op_valid),
        .out_ready(op_ready),
        .out_data(buf_out)
    );

    assign op_data = buf_out[OP_W*OC_SLOTS-1:0];
    assign op_mask = buf_out[OP_W*OC_SLOTS +: OC_SLOTS];
    assign op_thread = buf_out[BUF_W-2];
    assign op_from_cache = buf_out[BUF_W-1];
endmodule // fdoc_front_end
`default_nettype wire

// *** verification/fdoc_front_end_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdoc_front_end_sva
    import fdoc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic dual_thread_mode,
    input wire logic long_mode,
    input wire logic cs_base_zero,
    input wire logic cs_limit_max,
    input wire logic redirect_valid,
    input wire logic ic_req_valid,
    input wire logic ic_req_thread,
    input wire logic [ADDR_W-1:0] ic_req_addr,
    input wire logic decoded_supply_mode,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire logic [OC_SLOTS-1:0] op_mask,
    input wire logic [OP_W*OC_SLOTS-1:0] op_data,
    input wire logic op_from_cache
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_stall; op_valid && !op_ready; endsequence
    sequence s_held; op_valid && $stable(op_mask) && $stable(op_data); endsequence
    a_group_held: assert property (s_stall |=> s_held)
        else $error("group lost");
    a_req_aligned: assert property (
        ic_req_valid |-> ic_req_addr[4:0] == 5'h00) else $error("fetch align");
    a_decode_width: assert property (
        op_valid && !op_from_cache |-> op_mask[7:4] == 4'h0) else $error("decode width");
    a_mask_packed: assert property (
        op_valid |-> op_mask[0] && (op_mask & (op_mask + 8'h01)) == 8'h00) else $error("mask");
    a_entry_branch: assert property (
        $rose(decoded_supply_mode) |-> $past(redirect_valid)) else $error("mode entry");
    a_fetch_bypass: assert property (
        decoded_supply_mode && $past(decoded_supply_mode) |-> !ic_req_valid) else $error("bypass");
    a_flat_only: assert property (
        decoded_supply_mode |-> long_mode || (cs_base_zero && cs_limit_max)) else $error("flat");
    a_single_thread: assert property (
        !dual_thread_mode && ic_req_valid |-> !ic_req_thread) else $error("thread");
endmodule // fdoc_front_end_sva
bind fdoc_front_end fdoc_front_end_sva fdoc_front_end_sva_inst (.*);
`default_nettype wire

// *** verification/fdoc_icache_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdoc_icache_model
    import fdoc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic ic_req_valid,
    input wire logic [ADDR_W-1:0] ic_req_addr,
    output logic [BLOCK_BYTES*8-1:0] ic_rsp_data
);
    // 4-byte ops, pushes in odd 64-byte halves; data flips when idle
    always @(posedge sys_clk)
        if (ic_req_valid) begin
            for (int i = 0; i < BLOCK_BYTES; i++)
                ic_rsp_data[i*8 +: 8] <= (i % 4 == 0) ? {1'b0, ic_req_addr[6], 6'h03} : 8'(i);
        end else
            ic_rsp_data <= ~ic_rsp_data;
endmodule // fdoc_icache_model
`default_nettype wire

// *** verification/fdoc_front_end_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdoc_front_end_tb;
    import fdoc_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, long_mode = 1'b0, op_ready = 1'b0, saw_wide = 1'b0;
    logic dual_thread_mode = 1'b0, cs_base_zero = 1'b0, cs_limit_max = 1'b0, sp_sync = 1'b0;
    logic redirect_valid = 1'b0, redirect_thread = 1'b0;
    logic ic_req_valid, ic_req_thread, decoded_supply_mode, op_valid, op_thread, op_from_cache;
    logic [ADDR_W-1:0] redirect_addr = '0, ic_req_addr, exp_addr, base;
    logic [BLOCK_BYTES*8-1:0] ic_rsp_data;
    logic [OC_SLOTS-1:0] op_mask;
    logic [OP_W*OC_SLOTS-1:0] op_data;
    logic [15:0] lfsr_reg = 16'h50FD;
    logic [7:0] prev_off;
    int bad_count = 0, check_count = 0;
    always #25 sys_clk = ~sys_clk;
    fdoc_front_end fdoc_front_end_inst (.*);
    fdoc_icache_model fdoc_icache_model_inst (.*);
    function automatic logic [7:0] lead_byte(input logic [ADDR_W-1:0] a);
        return {1'b0, a[6], 6'h03};
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], ^(v & 16'hB400)};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic take_group();
        for (int i = 0; i < OC_SLOTS; i++) begin
            if (op_mask[i]) begin
                check("lead", op_data[16*i+8 +: 8], lead_byte(exp_addr));
                check("sp", op_data[16*i +: 8] - prev_off, exp_addr[6] ? 8'hF8 : 8'h00);
                prev_off = op_data[16*i +: 8];
                exp_addr += 4;
            end
        end
        check("thread", 8'(op_thread), 8'h00);
        check("src", 8'(op_from_cache), 8'(op_mask[4]));
        saw_wide |= op_mask[4];
    endtask
    // branch to a, drain groups older than the branch, then consume with random stalls
    task automatic run(input logic [ADDR_W-1:0] a, input logic hit, input int cycles);
        op_ready = 1'b1;
        redirect_valid = 1'b1;
        redirect_addr = a;
        sp_sync = 1'b1;
        @(posedge sys_clk);
        #1;
        redirect_valid = 1'b0;
        sp_sync = 1'b0;
        exp_addr = a;
        prev_off = 8'h00;
        check("mode", 8'(decoded_supply_mode), 8'(hit));
        // up to two stale groups leave the buffer at these two edges
        @(posedge sys_clk);
        #1;
        repeat (cycles) begin
            @(negedge sys_clk);
            if (op_valid && op_ready)
                take_group();
            @(posedge sys_clk);
            #1;
            lfsr_reg = lfsr_next(lfsr_reg);
            op_ready = lfsr_reg[0] | lfsr_reg[1];
        end
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        long_mode = 1'b1;
        base = {26'h0, lfsr_reg, 6'h00};
        run(base, 1'b0, 200);
        run(base, 1'b1, 300);
        check("wide", 8'(saw_wide), 8'h01);
        check("exit", 8'(decoded_supply_mode), 8'h00);
        tally_and_finish();
    end
endmodule // fdoc_front_end_tb
`default_nettype wire
